// file: vahm_angle_hold.sv
`timescale 1ns/1ps
// Notes on behaviour
// RL1: inactive whenever the enable setting is off
// RL2: all used voltages below collapse threshold
// RL3: optional qualifier needs one phase overcurrent
// RL4: collapse threshold clamped to 2..50 V
// RL5: output amplitude equals threshold while active
// RL6: pre-fault angles latched and held while active
// RL7: memory-in-use flag while active
// RL8: block input sampled per program cycle
// RL9: hold time limit 0.02..50 s, then withdraw
// RL10: after expiry request non-directional fallback
// RL11: fixed mode uses nominal 50/60 Hz
// RL12: forced tracking follows third phase current
// RL13: on/off events for low voltage, high current
// RL14: on/off events for current frequency tracking
// RL15: events for enable, memory use, blocking
// RL16: active ends on clear, block or disable
// RL17: no re-activation after expiry until cleared, blocked or disabled
module vahm_angle_hold (
  input  wire logic                       clk,
  input  wire logic                       rst_b,
  input  wire logic                       cycle_start,
  input  wire logic                       func_en,
  input  wire logic                       qual_en,
  input  wire logic                       freq_follow_en,
  input  wire logic                       nominal_60hz,
  input  wire logic                       block_in,
  input  wire logic [vahm_pkg::MAG_W-1:0] thr_level,
  input  wire logic [vahm_pkg::MAG_W-1:0] cur_pickup,
  input  wire logic [vahm_pkg::TMR_W-1:0] hold_limit,
  input  wire vahm_pkg::vahm_volt_s       volt,
  input  wire vahm_pkg::vahm_curr_s       curr,
  output logic                            mem_in_use,
  output vahm_pkg::vahm_ref_s             ref_out,
  output logic                            nondir_req,
  output logic                            fsel_current,
  output logic [1:0]                      fsel_channel,
  output logic                            nominal_60_out,
  output logic                            ev_valid,
  output logic [3:0]                      ev_code
);
  import vahm_pkg::*;

  vahm_state_s s_ff;
  vahm_state_s nxt_s;
  logic        nom_ff;

  // ----------------------------------------------------------------
  // condition detection
  // ----------------------------------------------------------------
  logic [MAG_W-1:0] thr_c;
  logic [TMR_W-1:0] lim_c;
  logic             ulow;
  logic             ihigh;
  logic             cond;
  logic             ftrk;
  logic [EV_N-1:0]  ev_set;

  always_comb begin
    thr_c = thr_level;
    if (thr_level < THR_MIN) begin
      thr_c = THR_MIN;                                         // [RL4]
    end else if (thr_level > THR_MAX) begin
      thr_c = THR_MAX;                                         // [RL4]
    end
    lim_c = hold_limit;
    if (hold_limit < HOLD_MIN) begin
      lim_c = HOLD_MIN;                                        // [RL9]
    end else if (hold_limit > HOLD_MAX) begin
      lim_c = HOLD_MAX;                                        // [RL9]
    end
  end

  // measurement selects line or phase set upstream via ll_mode
  assign ulow  = (volt.mag[0] < thr_c) && (volt.mag[1] < thr_c)
              && (volt.mag[2] < thr_c);                        // [RL2]
  assign ihigh = (curr.mag[0] > cur_pickup) || (curr.mag[1] > cur_pickup)
              || (curr.mag[2] > cur_pickup);
  assign cond  = ulow && (!qual_en || ihigh);                  // [RL3]
  // tracking only while voltages are gone
  assign ftrk  = func_en && freq_follow_en && ulow;            // [RL12]

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_s        = s_ff;
    ev_set       = '0;
    nxt_s.ulow   = ulow;
    nxt_s.ihigh  = ihigh;
    nxt_s.ftrk   = ftrk;
    nxt_s.en_d   = func_en;
    if (cycle_start) begin
      nxt_s.blk = block_in;                                    // [RL8]
    end

    // prescaler gives 10 ms steps of the hold timer
    if (s_ff.st == VAHM_ACTIVE) begin
      if (s_ff.pre == STEP_W'(STEP_CYC - 1)) begin
        nxt_s.pre = '0;
        nxt_s.tmr = s_ff.tmr + TMR_W'(1);
      end else begin
        nxt_s.pre = s_ff.pre + STEP_W'(1);
      end
    end

    case (s_ff.st)
      VAHM_IDLE: begin
        nxt_s.pre = '0;
        nxt_s.tmr = '0;
        // angles tracked in every idle cycle; frozen on entry
        nxt_s.last_ang = volt.ang;                             // [RL6]
        if (func_en && !s_ff.blk && cond) begin                // [RL1] [RL8]
          nxt_s.st             = VAHM_ACTIVE;
          nxt_s.last_ang       = s_ff.last_ang;                // [RL6]
        end
      end
      VAHM_ACTIVE: begin
        if (!func_en || s_ff.blk || !cond) begin               // [RL16]
          nxt_s.st  = VAHM_IDLE;
          nxt_s.tmr = '0;
          nxt_s.pre = '0;
        end else if (s_ff.tmr >= lim_c) begin                  // [RL9]
          nxt_s.st = VAHM_EXPIRED;
        end
      end
      VAHM_EXPIRED: begin
        if (!func_en || s_ff.blk || !cond) begin               // [RL17]
          nxt_s.st = VAHM_IDLE;
        end
      end
      default: nxt_s.st = VAHM_IDLE;
    endcase

    nxt_s.ref_o.held = (nxt_s.st == VAHM_ACTIVE);              // [RL7]
    if (nxt_s.st == VAHM_ACTIVE) begin
      nxt_s.ref_o.amp = thr_c;                                 // [RL5]
      nxt_s.ref_o.ang = nxt_s.last_ang;                        // [RL6]
    end else begin
      nxt_s.ref_o.amp = '0;                                    // [RL9]
      nxt_s.ref_o.ang = volt.ang;
    end
    nxt_s.nondir   = (nxt_s.st == VAHM_EXPIRED);               // [RL10]
    nxt_s.fsel_cur = ftrk;                                     // [RL12]
    nxt_s.fsel_ch  = ftrk ? CH_IL3 : 2'h0;                     // [RL12]
    // previous flag, so the event logic sees an edge of the held flag
    nxt_s.mem_d    = s_ff.ref_o.held;                          // [RL15]

    // ----------------------------------------------------------------
    // events: edges queue as pending bits, one emitted per clock
    // ----------------------------------------------------------------
    ev_set[EV_EN-1]        = func_en && !s_ff.en_d;            // [RL15]
    ev_set[EV_DIS-1]       = !func_en && s_ff.en_d;            // [RL15]
    ev_set[EV_ULOW_ON-1]   = ulow && !s_ff.ulow;               // [RL13]
    ev_set[EV_ULOW_OFF-1]  = !ulow && s_ff.ulow;               // [RL13]
    ev_set[EV_IHIGH_ON-1]  = ihigh && !s_ff.ihigh;             // [RL13]
    ev_set[EV_IHIGH_OFF-1] = !ihigh && s_ff.ihigh;             // [RL13]
    ev_set[EV_FTRK_ON-1]   = ftrk && !s_ff.ftrk;               // [RL14]
    ev_set[EV_FTRK_OFF-1]  = !ftrk && s_ff.ftrk;               // [RL14]
    ev_set[EV_MEM_ON-1]    = s_ff.ref_o.held && !s_ff.mem_d;   // [RL15]
    ev_set[EV_MEM_OFF-1]   = !s_ff.ref_o.held && s_ff.mem_d;   // [RL15]
    ev_set[EV_BLK_ON-1]    = nxt_s.blk && !s_ff.blk;           // [RL15]
    ev_set[EV_BLK_OFF-1]   = !nxt_s.blk && s_ff.blk;           // [RL15]

    nxt_s.ev_vld  = 1'b0;
    nxt_s.ev_code = EV_NONE;
    nxt_s.ev_pend = s_ff.ev_pend;
    for (int i = 0; i < EV_N; i++) begin
      if (!nxt_s.ev_vld && s_ff.ev_pend[i]) begin
        nxt_s.ev_vld     = 1'b1;
        nxt_s.ev_code    = 4'(i + 1);
        nxt_s.ev_pend[i] = 1'b0;
      end
    end
    // a new edge in the emitting cycle wins over the clear
    nxt_s.ev_pend = nxt_s.ev_pend | ev_set;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_ff          <= '0;
      s_ff.st       <= VAHM_IDLE;
      nom_ff        <= 1'b0;
    end else begin
      s_ff          <= nxt_s;
      nom_ff        <= nominal_60hz;                           // [RL11]
    end
  end

  assign mem_in_use     = s_ff.ref_o.held;
  assign ref_out        = s_ff.ref_o;
  assign nondir_req     = s_ff.nondir;
  assign fsel_current   = s_ff.fsel_cur;
  assign fsel_channel   = s_ff.fsel_ch;
  assign nominal_60_out = nom_ff;
  assign ev_valid       = s_ff.ev_vld;
  assign ev_code        = s_ff.ev_code;

endmodule : vahm_angle_hold

// file: vahm_pkg.sv
package vahm_pkg;

  // ----------------------------------------------------------------
  // widths and limits
  // ----------------------------------------------------------------
  localparam int MAG_W = 16;                          // magnitude, 0.01 V or 0.01 A units
  localparam int ANG_W = 16;                          // angle, 0.01 degree units
  localparam int TMR_W = 16;                          // hold time in 10 ms steps
  localparam logic [MAG_W-1:0] THR_MIN  = 16'h00C8;   // 2.00 V
  localparam logic [MAG_W-1:0] THR_MAX  = 16'h1388;   // 50.00 V
  localparam logic [TMR_W-1:0] HOLD_MIN = 16'h0002;   // 0.02 s
  localparam logic [TMR_W-1:0] HOLD_MAX = 16'h1388;   // 50.00 s
  localparam logic [1:0]       CH_IL3   = 2'h2;       // third_phase_current reference

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ       = 100_000_000;
  localparam int STEP_MS      = 10;
  localparam int STEP_CYC     = CLK_HZ / 1000 * STEP_MS;
  localparam int STEP_W       = 20;

  // ----------------------------------------------------------------
  // event codes
  // ----------------------------------------------------------------
  localparam logic [3:0] EV_NONE      = 4'h0;
  localparam logic [3:0] EV_EN        = 4'h1;
  localparam logic [3:0] EV_DIS       = 4'h2;
  localparam logic [3:0] EV_ULOW_ON   = 4'h3;
  localparam logic [3:0] EV_ULOW_OFF  = 4'h4;
  localparam logic [3:0] EV_IHIGH_ON  = 4'h5;
  localparam logic [3:0] EV_IHIGH_OFF = 4'h6;
  localparam logic [3:0] EV_FTRK_ON   = 4'h7;
  localparam logic [3:0] EV_FTRK_OFF  = 4'h8;
  localparam logic [3:0] EV_MEM_ON    = 4'h9;
  localparam logic [3:0] EV_MEM_OFF   = 4'hA;
  localparam logic [3:0] EV_BLK_ON    = 4'hB;
  localparam logic [3:0] EV_BLK_OFF   = 4'hC;
  localparam int         EV_N         = 12;

  typedef enum logic [2:0] {
    VAHM_IDLE    = 3'b001,
    VAHM_ACTIVE  = 3'b010,
    VAHM_EXPIRED = 3'b100
  } vahm_state_e;

  typedef struct packed {
    logic [2:0][MAG_W-1:0] mag;   // three voltages in use
    logic [2:0][ANG_W-1:0] ang;
    logic                  ll_mode;
  } vahm_volt_s;

  typedef struct packed {
    logic [2:0][MAG_W-1:0] mag;
  } vahm_curr_s;

  typedef struct packed {
    logic [MAG_W-1:0]      amp;
    logic [2:0][ANG_W-1:0] ang;
    logic                  held;
  } vahm_ref_s;

  typedef struct packed {
    vahm_state_e           st;
    logic                  en_d;
    logic                  blk;
    logic                  ulow;
    logic                  ihigh;
    logic                  ftrk;
    logic                  mem_d;
    logic [STEP_W-1:0]     pre;
    logic [TMR_W-1:0]      tmr;
    logic [2:0][ANG_W-1:0] last_ang;
    vahm_ref_s             ref_o;
    logic                  nondir;
    logic                  fsel_cur;
    logic [1:0]            fsel_ch;
    logic [EV_N-1:0]       ev_pend;
    logic                  ev_vld;
    logic [3:0]            ev_code;
  } vahm_state_s;

endpackage : vahm_pkg

// file: vahm_angle_hold_props.sv
`timescale 1ns/1ps
module vahm_angle_hold_props (
  input wire logic                 clk,
  input wire logic                 rst_b,
  input wire logic                 cycle_start,
  input wire logic                 block_in,
  input wire logic                 func_en,
  input wire logic                 qual_en,
  input wire logic                 freq_follow_en,
  input wire logic [15:0]          thr_level,
  input wire logic [15:0]          cur_pickup,
  input wire vahm_pkg::vahm_volt_s volt,
  input wire vahm_pkg::vahm_curr_s curr,
  input wire logic                 mem_in_use,
  input wire vahm_pkg::vahm_ref_s  ref_out,
  input wire logic                 nondir_req,
  input wire logic                 fsel_current,
  input wire logic [1:0]           fsel_channel,
  input wire logic                 ev_valid,
  input wire logic [3:0]           ev_code
);
  import vahm_pkg::*;
  logic [15:0] thr_c;
  logic        low;
  logic        hi;
  assign thr_c = thr_level < THR_MIN ? THR_MIN : (thr_level > THR_MAX ? THR_MAX : thr_level);
  assign low = volt.mag[0] < thr_c && volt.mag[1] < thr_c && volt.mag[2] < thr_c;
  assign hi = curr.mag[0] > cur_pickup || curr.mag[1] > cur_pickup || curr.mag[2] > cur_pickup;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_blocked;
    cycle_start && block_in ##1 !cycle_start;
  endsequence
  sequence s_mem_ev;
    ev_valid && ev_code == EV_MEM_ON;
  endsequence
  a_disabled_idle: assert property (!func_en |=> !mem_in_use)
    else $error("memory active while disabled");
  a_volt_needed: assert property (!low |=> !mem_in_use)
    else $error("memory active without collapse");
  a_qual_needed: assert property (qual_en && !hi |=> !mem_in_use)
    else $error("memory active without overcurrent");
  a_amp_is_thr: assert property (mem_in_use |-> ref_out.amp == $past(thr_c))
    else $error("amplitude differs from threshold");
  a_angles_held: assert property (mem_in_use && $past(mem_in_use) |-> $stable(ref_out.ang))
    else $error("held angles moved");
  a_flag_matches: assert property (ref_out.held == mem_in_use)
    else $error("held flag differs from memory flag");
  a_block_stops: assert property (s_blocked |=> !mem_in_use)
    else $error("memory active while blocked");
  a_no_overlap: assert property (!(mem_in_use && nondir_req))
    else $error("fallback raised while memory active");
  a_follow_chan: assert property (fsel_channel == (fsel_current ? CH_IL3 : 2'h0))
    else $error("wrong follow channel");
  a_follow_off: assert property (!freq_follow_en ##1 !freq_follow_en |=> !fsel_current)
    else $error("following current while option off");
  a_mem_event: assert property ($rose(mem_in_use) |-> ##[1:14] s_mem_ev)
    else $error("memory start event missing");
  a_event_code: assert property (ev_valid |-> ev_code inside {[EV_EN:EV_BLK_OFF]})
    else $error("event code out of range");
endmodule : vahm_angle_hold_props
bind vahm_angle_hold vahm_angle_hold_props vahm_angle_hold_props_inst (.clk, .rst_b,
  .cycle_start, .block_in, .func_en, .qual_en, .freq_follow_en, .thr_level, .cur_pickup,
  .volt, .curr, .mem_in_use, .ref_out, .nondir_req, .fsel_current, .fsel_channel,
  .ev_valid, .ev_code);

// file: vahm_front_end.sv
`timescale 1ns/1ps
module vahm_front_end (
  input  wire logic          clk,
  input  wire logic          rst_b,
  input  wire logic [1:0]    mode,
  output vahm_pkg::vahm_volt_s volt,
  output vahm_pkg::vahm_curr_s curr
);
  // angles keep moving after collapse, so a held copy is told apart from live ones
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      volt <= '0;
      curr <= '0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        volt.mag[i] <= mode == 2'h0 ? 16'h59d8 : (mode == 2'h3 ? 16'h00c8 : 16'h0064 + 16'(i));
        volt.ang[i] <= volt.ang[i] + 16'h0007 + 16'(i);
        curr.mag[i] <= (mode == 2'h2 && i == 2) ? 16'h1388 : 16'h0064;
      end
    end
  end
endmodule : vahm_front_end

// file: vahm_angle_hold_bench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin miscompares++; \
  $display("wrong value at %0t: %0h vs %0h", $time, g, e); end end
module vahm_angle_hold_bench;
  import vahm_pkg::*;
  logic clk = 0, rst_b = 0, cycle_start = 0, func_en = 0, qual_en = 0;
  logic freq_follow_en = 0, nominal_60hz = 0, block_in = 0, mem_in_use, nondir_req;
  logic fsel_current, nominal_60_out, ev_valid, blk_m, mem_m, cond_m, hi_m;
  logic [1:0] mode = 0, fsel_channel;
  logic [3:0] ev_code;
  logic [15:0] thr_level = 16'h01f4, cur_pickup = 16'h03e8, hold_limit = 16'h0002, amp_m;
  logic [2:0][15:0] held_m, ang_q;
  vahm_volt_s volt;
  vahm_curr_s curr;
  vahm_ref_s ref_out;
  int miscompares = 0, check_count = 0, cyc = 0, seed = 32'h0000_bfb8;
  vahm_front_end vahm_front_end_inst (.clk, .rst_b, .mode, .volt, .curr);
  vahm_angle_hold vahm_angle_hold_inst (.clk, .rst_b, .cycle_start, .func_en, .qual_en,
    .freq_follow_en, .nominal_60hz, .block_in, .thr_level, .cur_pickup, .hold_limit, .volt,
    .curr, .mem_in_use, .ref_out, .nondir_req, .fsel_current, .fsel_channel, .nominal_60_out,
    .ev_valid, .ev_code);
  always #5 clk = ~clk;
  function automatic logic [15:0] clampv(logic [15:0] t);
    return t < THR_MIN ? THR_MIN : (t > THR_MAX ? THR_MAX : t);
  endfunction : clampv
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      blk_m <= 0;
      mem_m <= 0;
    end else begin
      cond_m = func_en && !blk_m;
      hi_m = 0;
      for (int i = 0; i < 3; i++) begin
        cond_m &= volt.mag[i] < clampv(thr_level);
        hi_m |= curr.mag[i] > cur_pickup;
      end
      if (qual_en) cond_m &= hi_m;
      if (cond_m && !mem_m) held_m <= ang_q;
      mem_m <= cond_m;
      ang_q <= volt.ang;
      amp_m <= clampv(thr_level);
      if (cycle_start) blk_m <= block_in;
    end
  end
  always @(negedge clk) begin
    cyc++;
    cycle_start <= cyc % 8 == 0;
    if (rst_b) begin
      `CHK(mem_in_use, mem_m)
      if (mem_m) begin
        `CHK(ref_out.amp, amp_m)
        `CHK(ref_out.ang, held_m)
      end
    end
  end
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  task automatic wait_ev(input logic [3:0] code);
    int n;
    n = 0;
    while (!(ev_valid === 1'b1 && ev_code === code) && n < 40) begin
      @(negedge clk);
      n++;
    end
    `CHK(n < 40, 1'b1)
    if (n == 40) tally_and_finish();
  endtask : wait_ev
  initial begin
    repeat (4) @(negedge clk);
    rst_b = 1;
    @(negedge clk);
    `CHK({nondir_req, ev_valid, fsel_current}, 3'h0)
    mode = 1;
    wait_ev(EV_ULOW_ON);
    repeat (20) @(negedge clk);
    func_en = 1;
    wait_ev(EV_EN);
    wait_ev(EV_MEM_ON);
    repeat (30) @(negedge clk);
    mode = 0;
    wait_ev(EV_ULOW_OFF);
    wait_ev(EV_MEM_OFF);
    qual_en = 1;
    mode = 1;
    repeat (20) @(negedge clk);
    mode = 2;
    wait_ev(EV_IHIGH_ON);
    wait_ev(EV_MEM_ON);
    block_in = 1;
    wait_ev(EV_BLK_ON);
    wait_ev(EV_MEM_OFF);
    repeat (20) @(negedge clk);
    block_in = 0;
    wait_ev(EV_BLK_OFF);
    wait_ev(EV_MEM_ON);
    freq_follow_en = 1;
    wait_ev(EV_FTRK_ON);
    `CHK({fsel_current, fsel_channel}, {1'b1, CH_IL3})
    freq_follow_en = 0;
    wait_ev(EV_FTRK_OFF);
    for (int v = 0; v < 4; v++) begin
      nominal_60hz = v[0];
      repeat (2) @(negedge clk);
      `CHK(nominal_60_out, v[0])
    end
    for (int k = 0; k < 10; k++) begin
      thr_level = k == 0 ? 16'h0000 : (k == 1 ? 16'h00c9 : 16'($random(seed)));
      mode = k < 2 ? 2'h3 : 2'($random(seed));
      qual_en = k[0];
      repeat (12) @(negedge clk);
    end
    func_en = 0;
    wait_ev(EV_DIS);
    tally_and_finish();
  end
endmodule : vahm_angle_hold_bench
